// ===== dct_pkg.sv
//  Function
//  - Enable loads reload buffer, then counts down
//  - Disable halts; buffer address reads counter
//  - Stopped write to buffer loads counter
//  - 8-bit wrap sets flag, interrupts, reloads
//  - 8-bit wrap flag readable and writable
//  - Source bit picks external pin or system clock
//  - 8-bit prescaler divides system clock 1..16
//  - External source ignores the prescaler field
//  - 16-bit counter, reload from two bytes
//  - PWM clear gives plain 16-bit counting
//  - 16-bit wrap sets flag and interrupts
//  - 16-bit reload on enable and wrap
//  - 16-bit stop; stopped writes pass through
//  - 16-bit prescaler divides oscillator 1..16
//  - PWM alternates low and high periods
package dct_pkg;
   // ----------------------------------------------------------------
   // Register offsets.
   // ----------------------------------------------------------------
   localparam logic [7:0] DCT_ADDR_T8_BUF = 8'h04;
   localparam logic [7:0] DCT_ADDR_T8_CTL = 8'h05;
   localparam logic [7:0] DCT_ADDR_T16_LO = 8'h06;
   localparam logic [7:0] DCT_ADDR_T16_HI = 8'h07;
   localparam logic [7:0] DCT_ADDR_T16_CTL = 8'h08;
   localparam logic [7:0] DCT_ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] DCT_ADDR_IRQ_MASK = 8'h21;

   // ----------------------------------------------------------------
   // Control field positions.
   // ----------------------------------------------------------------
   localparam int DCT_BIT_RUN = 7;
   localparam int DCT_BIT_FLAG = 6;
   localparam int DCT_BIT_SRC = 5;
   localparam int DCT_BIT_PWM = 4;
   localparam int DCT_BIT_PSC_HI = 2;
   localparam int DCT_BIT_IRQ_T8 = 0;
   localparam int DCT_BIT_IRQ_T16 = 1;

   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] DCT_RST_BYTE = 8'h00;
   localparam logic [15:0] DCT_RST_WORD = 16'h0000;
   localparam logic [2:0] DCT_RST_PSC = 3'h0;
   localparam logic [3:0] DCT_RST_PRE = 4'h0;
   localparam logic [1:0] DCT_RST_IRQ = 2'h0;
endpackage : dct_pkg

// ===== dct_top.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module dct_top
   import dct_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // System clock enable from the clock divider
   input wire logic i_fsys_en,
   // External clock pin
   input wire logic i_external_clock_pin,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Events and outputs
   output logic o_irq,
   output logic o_timer16_pwm
);

   typedef struct packed {
      logic ext_s1;
      logic ext_s2;
      logic ext_prev;
      logic [7:0] t8_cnt;
      logic [7:0] t8_buf;
      logic t8_run;
      logic t8_flag;
      logic t8_src;
      logic [2:0] t8_psc;
      logic [3:0] t8_pre;
      logic [15:0] t16_cnt;
      logic [7:0] t16_lo;
      logic [7:0] t16_hi;
      logic t16_run;
      logic t16_flag;
      logic t16_src;
      logic t16_pwm;
      logic [2:0] t16_psc;
      logic [3:0] t16_pre;
      logic t16_phase;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [7:0] rdata;
   } dct_state_t;

   dct_state_t s_q;
   dct_state_t s_d;
   logic [1:0] rst_sync_q;
   logic rst_n;

   // ----------------------------------------------------------------
   // Reset release.
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------------------------------
   // Prescaler mask: divide by 1, 2, 4, 8, or 16 when bit 2 is set.
   // ----------------------------------------------------------------
   function automatic logic [3:0] dct_psc_mask(input logic [2:0] sel);
      logic [3:0] m;
      m = 4'h0;
      if (sel[DCT_BIT_PSC_HI]) begin
         m = 4'hf;
      end else begin
         case (sel[1:0])
            2'h0: m = 4'h0;
            2'h1: m = 4'h1;
            2'h2: m = 4'h3;
            2'h3: m = 4'h7;
            default: m = 4'h0;
         endcase
      end
      return m;
   endfunction : dct_psc_mask

   // ----------------------------------------------------------------
   // Prescaler taps, one per timer.
   // ----------------------------------------------------------------
   logic [1:0] base_en;
   logic [1:0] pre_hit;
   logic [3:0] pre_now [2];
   logic [3:0] pre_step [2];
   logic [2:0] psc_now [2];

   assign base_en[0] = i_fsys_en;
   assign base_en[1] = 1'b1;
   assign pre_now[0] = s_q.t8_pre;
   assign pre_now[1] = s_q.t16_pre;
   assign psc_now[0] = s_q.t8_psc;
   assign psc_now[1] = s_q.t16_psc;

   for (genvar g = 0; g < 2; g++) begin : g_psc
      logic [3:0] tap_mask;
      assign tap_mask = dct_psc_mask(psc_now[g]);
      assign pre_step[g] = base_en[g] ? pre_now[g] + 4'h1 : pre_now[g];
      assign pre_hit[g] = base_en[g] && ((pre_now[g] & tap_mask) == tap_mask);
   end

   // ----------------------------------------------------------------
   // Next state.
   // ----------------------------------------------------------------
   always_comb begin
      logic ext_edge;
      logic t8_tick;
      logic t16_tick;
      logic t8_wrap;
      logic t16_wrap;
      logic wr8_ctl;
      logic wr16_ctl;
      logic [1:0] clr;
      ext_edge = 1'b0;
      t8_tick = 1'b0;
      t16_tick = 1'b0;
      t8_wrap = 1'b0;
      t16_wrap = 1'b0;
      wr8_ctl = i_wr && (i_addr == DCT_ADDR_T8_CTL);
      wr16_ctl = i_wr && (i_addr == DCT_ADDR_T16_CTL);
      clr = 2'h0;
      s_d = s_q;

      // Pin synchroniser and rising edge.
      s_d.ext_s1 = i_external_clock_pin;
      s_d.ext_s2 = s_q.ext_s1;
      s_d.ext_prev = s_q.ext_s2;
      ext_edge = s_q.ext_s2 && !s_q.ext_prev;

      // 8-bit timer clock selection.
      // system clock prescale
      s_d.t8_pre = pre_step[0];
      if (s_q.t8_src) begin
         t8_tick = ext_edge;
      end else begin
         t8_tick = pre_hit[0];
      end

      // 16-bit timer clock selection.
      // oscillator prescale
      s_d.t16_pre = pre_step[1];
      if (s_q.t16_src) begin
         t16_tick = ext_edge;
      end else begin
         t16_tick = pre_hit[1];
      end

      // 8-bit counting.
      // stop halts counting
      if (s_q.t8_run && t8_tick) begin
         if (s_q.t8_cnt == 8'h00) begin
            t8_wrap = 1'b1;
            s_d.t8_cnt = s_q.t8_buf;
         end else begin
            s_d.t8_cnt = s_q.t8_cnt - 8'h01;
         end
      end

      // 16-bit counting.
      // down count; PWM wrap reloads hi or lo byte by phase
      if (s_q.t16_run && t16_tick) begin
         if (s_q.t16_cnt == 16'h0000) begin
            t16_wrap = 1'b1;
            if (s_q.t16_pwm) begin
               s_d.t16_phase = !s_q.t16_phase;
               s_d.t16_cnt = {8'h00, s_q.t16_phase ? s_q.t16_lo : s_q.t16_hi};
            end else begin
               s_d.t16_cnt = {s_q.t16_hi, s_q.t16_lo};
            end
         end else begin
            s_d.t16_cnt = s_q.t16_cnt - 16'h0001;
         end
      end

      // Register writes.
      if (i_wr) begin
         case (i_addr)
            DCT_ADDR_T8_BUF: begin
               s_d.t8_buf = i_wdata;
               if (!s_q.t8_run) begin
                  s_d.t8_cnt = i_wdata;
               end
            end
            DCT_ADDR_T8_CTL: begin
               s_d.t8_run = i_wdata[DCT_BIT_RUN];
               s_d.t8_src = i_wdata[DCT_BIT_SRC];
               s_d.t8_psc = i_wdata[2:0];
               if (i_wdata[DCT_BIT_RUN] && !s_q.t8_run) begin
                  s_d.t8_cnt = s_q.t8_buf;
                  s_d.t8_pre = DCT_RST_PRE;
               end
            end
            DCT_ADDR_T16_LO: begin
               s_d.t16_lo = i_wdata;
               if (!s_q.t16_run) begin
                  s_d.t16_cnt[7:0] = i_wdata;
               end
            end
            DCT_ADDR_T16_HI: begin
               s_d.t16_hi = i_wdata;
               if (!s_q.t16_run) begin
                  s_d.t16_cnt[15:8] = i_wdata;
               end
            end
            DCT_ADDR_T16_CTL: begin
               s_d.t16_run = i_wdata[DCT_BIT_RUN];
               s_d.t16_src = i_wdata[DCT_BIT_SRC];
               s_d.t16_pwm = i_wdata[DCT_BIT_PWM];
               s_d.t16_psc = i_wdata[2:0];
               if (i_wdata[DCT_BIT_RUN] && !s_q.t16_run) begin
                  s_d.t16_pre = DCT_RST_PRE;
                  s_d.t16_phase = 1'b0;
                  if (i_wdata[DCT_BIT_PWM]) begin
                     s_d.t16_cnt = {8'h00, s_q.t16_lo};
                  end else begin
                     s_d.t16_cnt = {s_q.t16_hi, s_q.t16_lo};
                  end
               end
            end
            DCT_ADDR_IRQ_STAT: begin
               clr = i_wdata[1:0];
            end
            DCT_ADDR_IRQ_MASK: begin
               s_d.irq_mask = i_wdata[1:0];
            end
            default: begin
               s_d.irq_mask = s_q.irq_mask;
            end
         endcase
      end

      // Wrap flags.
      // flag written by software
      if (wr8_ctl) begin
         s_d.t8_flag = i_wdata[DCT_BIT_FLAG] || t8_wrap;
      end else if (t8_wrap) begin
         s_d.t8_flag = 1'b1;
      end
      if (wr16_ctl) begin
         s_d.t16_flag = i_wdata[DCT_BIT_FLAG] || t16_wrap;
      end else if (t16_wrap) begin
         s_d.t16_flag = 1'b1;
      end

      // Sticky interrupt status, cleared by writing one.
      s_d.irq_stat = (s_q.irq_stat & ~clr) | {t16_wrap, t8_wrap};

      // Register reads.
      s_d.rdata = DCT_RST_BYTE;
      if (i_rd) begin
         case (i_addr)
            DCT_ADDR_T8_BUF: s_d.rdata = s_q.t8_cnt;
            DCT_ADDR_T8_CTL: s_d.rdata = {s_q.t8_run, s_q.t8_flag, s_q.t8_src, 2'h0, s_q.t8_psc};
            DCT_ADDR_T16_LO: s_d.rdata = s_q.t16_lo;
            DCT_ADDR_T16_HI: s_d.rdata = s_q.t16_hi;
            DCT_ADDR_T16_CTL: s_d.rdata = {s_q.t16_run, s_q.t16_flag, s_q.t16_src, s_q.t16_pwm, 1'b0, s_q.t16_psc};
            DCT_ADDR_IRQ_STAT: s_d.rdata = {6'h00, s_q.irq_stat};
            DCT_ADDR_IRQ_MASK: s_d.rdata = {6'h00, s_q.irq_mask};
            default: s_d.rdata = DCT_RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q.ext_s1 <= 1'b0;
         s_q.ext_s2 <= 1'b0;
         s_q.ext_prev <= 1'b0;
         s_q.t8_cnt <= DCT_RST_BYTE;
         s_q.t8_buf <= DCT_RST_BYTE;
         s_q.t8_run <= 1'b0;
         s_q.t8_flag <= 1'b0;
         s_q.t8_src <= 1'b0;
         s_q.t8_psc <= DCT_RST_PSC;
         s_q.t8_pre <= DCT_RST_PRE;
         s_q.t16_cnt <= DCT_RST_WORD;
         s_q.t16_lo <= DCT_RST_BYTE;
         s_q.t16_hi <= DCT_RST_BYTE;
         s_q.t16_run <= 1'b0;
         s_q.t16_flag <= 1'b0;
         s_q.t16_src <= 1'b0;
         s_q.t16_pwm <= 1'b0;
         s_q.t16_psc <= DCT_RST_PSC;
         s_q.t16_pre <= DCT_RST_PRE;
         s_q.t16_phase <= 1'b0;
         s_q.irq_stat <= DCT_RST_IRQ;
         s_q.irq_mask <= DCT_RST_IRQ;
         s_q.rdata <= DCT_RST_BYTE;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   assign o_rdata = s_q.rdata;
   assign o_irq = |(s_q.irq_stat & s_q.irq_mask);
   assign o_timer16_pwm = s_q.t16_phase;

endmodule : dct_top

// ===== dct_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the timer pair.
// ----------------------------------------
module dct_sva
   import dct_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_fsys_en,
   input wire logic i_external_clock_pin,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic o_irq,
   input wire logic o_timer16_pwm
);
   logic run_q;
   logic pwm_q;
   logic [1:0] mask_q;
   logic rd8;
   assign rd8 = i_rd && i_addr == DCT_ADDR_T8_BUF;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         run_q <= 1'b0;
         pwm_q <= 1'b0;
         mask_q <= 2'h0;
      end else if (i_wr) begin
         if (i_addr == DCT_ADDR_T8_CTL) run_q <= i_wdata[DCT_BIT_RUN];
         if (i_addr == DCT_ADDR_T16_CTL) pwm_q <= i_wdata[DCT_BIT_PWM];
         if (i_addr == DCT_ADDR_IRQ_MASK) mask_q <= i_wdata[1:0];
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   property p_rd_idle;
      !i_rd |=> o_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("idle read data");
   property p_ctl_rsvd;
      i_rd && i_addr == DCT_ADDR_T8_CTL |=> o_rdata[4:3] == 2'h0;
   endproperty
   a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control spare bits");
   property p_t16_rsvd;
      i_rd && i_addr == DCT_ADDR_T16_CTL |=> !o_rdata[3];
   endproperty
   a_t16_rsvd: assert property (p_t16_rsvd) else $error("wide control bit3");
   property p_irq_mask;
      o_irq |-> mask_q != 2'h0;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
   property p_stop_load;
      !run_q && i_wr && i_addr == DCT_ADDR_T8_BUF ##1 !i_wr ##1 rd8 |=> o_rdata == $past(i_wdata, 3);
   endproperty
   a_stop_load: assert property (p_stop_load) else $error("stopped load");
   property p_stop_hold;
      !run_q && rd8 ##1 rd8 |=> o_rdata == $past(o_rdata);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped count moved");
   property p_pwm_rose;
      $rose(o_timer16_pwm) |-> pwm_q;
   endproperty
   a_pwm_rose: assert property (p_pwm_rose) else $error("phase out of mode");
   property p_flag_clr;
      !run_q && i_wr && i_addr == DCT_ADDR_T8_CTL && i_wdata[7:6] == 2'h0 ##1 !i_wr
         ##1 i_rd && i_addr == DCT_ADDR_T8_CTL |=> !o_rdata[DCT_BIT_FLAG];
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
endmodule : dct_sva
bind dct_top dct_sva u_sva (.i_clk(i_clk), .i_resetn(i_resetn), .i_fsys_en(i_fsys_en),
   .i_external_clock_pin(i_external_clock_pin), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_timer16_pwm(o_timer16_pwm));

// ===== tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the timer pair.
// ----------------------------------------
module tb;
   import dct_pkg::*;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_fsys_en = 1'b1;
   logic i_external_clock_pin = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic o_irq;
   logic o_timer16_pwm;
   logic slow = 1'b0;
   logic [7:0] d1, d2;
   logic [2:0] ps [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   dct_top i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_fsys_en(i_fsys_en),
      .i_external_clock_pin(i_external_clock_pin), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_timer16_pwm(o_timer16_pwm));
   always #2.5 i_clk = ~i_clk;
   task automatic report_and_stop;
      $display("mismatches %0d checks %0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      i_fsys_en <= slow ? ~i_fsys_en : 1'b1;
      if (cyc == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd2(input logic [7:0] a, output logic [7:0] x, output logic [7:0] y);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(negedge i_clk);
      @(negedge i_clk);
      x = o_rdata;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      y = o_rdata;
   endtask : rd2
   task automatic wt(input bit p, input logic v, output int t);
      int n;
      n = 0;
      @(negedge i_clk);
      while ((p ? o_timer16_pwm : o_irq) !== v && n < 2000) begin
         @(negedge i_clk);
         n++;
      end
      chk("wait", {7'h0, v}, {7'h0, p ? o_timer16_pwm : o_irq});
      t = cyc;
   endtask : wt
   task automatic t_regs;
      rd2(DCT_ADDR_T8_CTL, d1, d2);
      chk("t8ctl", 8'h00, d1);
      rd2(8'h30, d1, d2);
      chk("unmapped", 8'h00, d1);
      wr(DCT_ADDR_T8_BUF, 8'h5a);
      rd2(DCT_ADDR_T8_BUF, d1, d2);
      chk("load", 8'h5a, d1);
      chk("hold", 8'h5a, d2);
      wr(DCT_ADDR_T16_LO, 8'ha5);
      rd2(DCT_ADDR_T16_LO, d1, d2);
      chk("t16lo", 8'ha5, d1);
      rd2(DCT_ADDR_T16_CTL, d1, d2);
      chk("t16ctl", 8'h00, d1);
   endtask : t_regs
   task automatic t_irq;
      wr(DCT_ADDR_IRQ_MASK, 8'h00);
      wr(DCT_ADDR_T8_BUF, 8'h00);
      wr(DCT_ADDR_T8_CTL, 8'h80);
      repeat (4) @(negedge i_clk);
      chk("masked", 8'h00, {7'h0, o_irq});
      rd2(DCT_ADDR_IRQ_STAT, d1, d2);
      chk("stat", 8'h01, d1 & 8'h01);
      rd2(DCT_ADDR_T8_CTL, d1, d2);
      chk("flag", 8'hc0, d1 & 8'hc0);
      wr(DCT_ADDR_IRQ_MASK, 8'h01);
      @(negedge i_clk);
      chk("irq", 8'h01, {7'h0, o_irq});
      wr(DCT_ADDR_T8_CTL, 8'h00);
      wr(DCT_ADDR_T8_CTL, 8'h00);
      rd2(DCT_ADDR_T8_CTL, d1, d2);
      chk("flagclr", 8'h00, d1);
      rd2(DCT_ADDR_T8_BUF, d1, d2);
      chk("halt", 8'h00, d1);
      chk("halt2", 8'h00, d2);
      wr(DCT_ADDR_IRQ_STAT, 8'h01);
      @(negedge i_clk);
      chk("irqclr", 8'h00, {7'h0, o_irq});
   endtask : t_irq
   task automatic t_period(input logic [7:0] c, input logic [7:0] ca, input logic [7:0] ba, input int e);
      int t0, t1;
      wr(DCT_ADDR_IRQ_MASK, 8'h03);
      wr(ba, 8'h03);
      wr(ca, c);
      wt(1'b0, 1'b1, t0);
      wr(DCT_ADDR_IRQ_STAT, 8'h03);
      wt(1'b0, 1'b1, t1);
      chk("period", e[7:0], 8'(t1 - t0));
      wr(ca, 8'h00);
      wr(DCT_ADDR_IRQ_STAT, 8'h03);
   endtask : t_period
   task automatic t_ext;
      for (int k = 0; k < 2; k++) begin
         wr(k ? DCT_ADDR_T16_LO : DCT_ADDR_T8_BUF, 8'h02);
         wr(k ? DCT_ADDR_T16_CTL : DCT_ADDR_T8_CTL, 8'ha3);
         for (int i = 0; i < 8; i++) begin
            repeat (6) @(posedge i_clk);
            i_external_clock_pin <= ~i_external_clock_pin;
            @(negedge i_clk);
            chk("ext", {7'h0, i >= 5}, {7'h0, o_irq});
         end
         wr(k ? DCT_ADDR_T16_CTL : DCT_ADDR_T8_CTL, 8'h00);
         wr(DCT_ADDR_IRQ_STAT, 8'h03);
      end
   endtask : t_ext
   task automatic t_pwm;
      int t0, t1, t2;
      wr(DCT_ADDR_T16_LO, 8'h02);
      wr(DCT_ADDR_T16_HI, 8'h05);
      wr(DCT_ADDR_T16_CTL, 8'h90);
      wt(1'b1, 1'b1, t0);
      wt(1'b1, 1'b0, t1);
      wt(1'b1, 1'b1, t2);
      chk("pwmhi", 8'h06, 8'(t1 - t0));
      chk("pwmlo", 8'h03, 8'(t2 - t1));
      wr(DCT_ADDR_T16_CTL, 8'h00);
   endtask : t_pwm
   initial begin
      repeat (4) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_clk);
      t_regs();
      t_irq();
      for (int i = 0; i < 5; i++) begin
         t_period(8'h80 | ps[i], DCT_ADDR_T8_CTL, DCT_ADDR_T8_BUF, 4 << i);
         t_period(8'h80 | ps[i], DCT_ADDR_T16_CTL, DCT_ADDR_T16_LO, 4 << i);
      end
      slow <= 1'b1;
      t_period(8'h80, DCT_ADDR_T8_CTL, DCT_ADDR_T8_BUF, 8);
      slow <= 1'b0;
      t_ext();
      t_pwm();
      report_and_stop();
   end
endmodule : tb
